// >>> inc/angle_pwm_pkg.sv
// Constants shared by the angle PWM output encoder.
package angle_pwm_pkg;
  // Clock rate and angle refresh interval.
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned ANG_UPDATE_US  = 1;
  localparam int unsigned ANG_UPDATE_CYC = (ANG_UPDATE_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned ANG_UPDATE_CLK = (ANG_UPDATE_CYC < 1) ? 1 : ANG_UPDATE_CYC;

  // Widths.
  localparam int unsigned ANGLE_W  = 12;
  localparam int unsigned PERIOD_W = 20;
  localparam int unsigned FAULT_N  = 13;
  localparam int unsigned PTR_W    = 8;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] PERIOD_OFS  = 8'h04;
  localparam logic [7:0] STATUS_OFS  = 8'h08;
  localparam logic [7:0] ANGLE_OFS   = 8'h0C;
  localparam logic [7:0] WRPTR_OFS   = 8'h10;

  // Control register fields.
  localparam int unsigned CTRL_ERR_EN_BIT   = 0;
  localparam int unsigned CTRL_ERR_SEL_BIT  = 1;
  localparam int unsigned CTRL_TURN_CLR_BIT = 2;
  localparam int unsigned CTRL_MASKA_BIT    = 3;
  localparam int unsigned CTRL_MASKM_BIT    = 4;

  // Status register fields.
  localparam int unsigned STAT_REPORT_LSB = 0;
  localparam int unsigned STAT_ERR_BIT    = 16;
  localparam int unsigned STAT_HIZ_BIT    = 17;
  localparam int unsigned STAT_INIT_BIT   = 18;

  // Reset values.
  localparam logic [PTR_W-1:0] WRPTR_RESET = 8'h00;

  // Duty limits and fault codes in units of 1/1600 of a period.
  localparam int unsigned DUTY_DEN   = 1600;
  localparam int unsigned DUTY_MIN   = 80;
  localparam int unsigned DUTY_SPAN  = 1440;
  localparam int unsigned CODE_FIRST = 80;
  localparam int unsigned CODE_STEP  = 90;

  // Fault indices, in priority order (index 0 is the highest priority).
  typedef enum logic [3:0] {
    F_WATCHDOG = 4'h0, F_EE_UNCORR = 4'h1, F_SELFTEST = 4'h2, F_PLL = 4'h3,
    F_ZERO_CROSS = 4'h4, F_MEAN = 4'h5, F_SUPPLY = 4'h6, F_WEAK = 4'h7,
    F_EE_CORR = 4'h8, F_CLIP = 4'h9, F_STRONG = 4'hA, F_TEMP = 4'hB, F_TURNS = 4'hC
  } fault_idx_t;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// >>> core/angle_pwm_error_encoder.sv
// Angle PWM output with prioritised fault duty codes and AXI4-Lite registers.
`timescale 1ns/1ps

module angle_pwm_error_encoder #(
  parameter int unsigned INIT_CYCLES = 2000,
  parameter int unsigned ADDR_W      = 8
) (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  // AXI4-Lite slave.
  input  wire logic [ADDR_W-1:0]                 s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [ADDR_W-1:0]                 s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  // Angle from the data path and EEPROM shadow configuration.
  input  wire logic [angle_pwm_pkg::ANGLE_W-1:0] angle_in,
  input  wire logic                              ee_pwm_error_output_enable,
  input  wire logic                              ee_pwm_error_signalling_select,
  input  wire logic                              ee_mask_analog,
  input  wire logic                              ee_mask_main,
  input  wire logic [angle_pwm_pkg::PERIOD_W-1:0] ee_period,
  // Fault sources.
  input  wire logic                              watchdog_fault,
  input  wire logic                              eeprom_uncorrectable_fault,
  input  wire logic                              selftest_fault,
  input  wire logic                              pll_unlock_fault,
  input  wire logic                              zero_cross_integrity_fault,
  input  wire logic                              mean_filter_fault,
  input  wire logic                              analog_supply_undervoltage,
  input  wire logic                              main_supply_undervoltage,
  input  wire logic                              weak_field_fault,
  input  wire logic                              eeprom_corrected_fault,
  input  wire logic                              clip_fault,
  input  wire logic                              strong_field_fault,
  input  wire logic                              temperature_window_fault,
  input  wire logic                              turn_count_overflow,
  // PWM pin.
  output logic                                   pwm_o,
  output logic                                   pwm_oe
);
  import angle_pwm_pkg::*;

  localparam int unsigned INIT_W = $clog2(INIT_CYCLES + 1);
  localparam int unsigned ANGC_W = $clog2(ANG_UPDATE_CLK + 1);

  logic [INIT_W-1:0]   init_cnt_q;
  logic                init_done_q;
  logic                init_load;
  logic                err_en_q;
  logic                err_sel_q;
  logic                mask_a_q;
  logic                mask_m_q;
  logic [PERIOD_W-1:0] period_q;
  logic [PTR_W-1:0]    wrptr_q;
  logic [ANGC_W-1:0]   ang_cnt_q;
  logic [ANGLE_W-1:0]  angle_q;
  logic [FAULT_N-1:0]  live;
  logic [FAULT_N-1:0]  perm_q;
  logic                turns_q;
  logic [FAULT_N-1:0]  seen_q;
  logic [FAULT_N-1:0]  report_q;
  logic                err_rep;
  logic                hiz_q;
  logic [PERIOD_W:0]   cnt_q;
  logic [PERIOD_W:0]   cur_period_q;
  logic [PERIOD_W:0]   high_q;
  logic [PERIOD_W:0]   next_period;
  logic [PERIOD_W:0]   next_high;
  logic                period_end;
  logic [10:0]         code;
  logic                aw_got_q;
  logic                w_got_q;
  logic [ADDR_W-1:0]   awaddr_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  logic                wr_fire;
  logic                turn_clear;
  logic [31:0]         rd_val;
  logic                rd_hit;

  //////////////////////////////////////////////////////////////////////////////
  // Power-on initialisation.

  // Count the init time; configuration is copied from the shadow bits once at its end.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      init_cnt_q  <= '0;
      init_done_q <= 1'b0;
    end else if (!init_done_q) begin
      if (init_cnt_q == INIT_W'(INIT_CYCLES)) begin
        init_done_q <= 1'b1;
      end else begin
        init_cnt_q <= init_cnt_q + INIT_W'(1);
      end
    end
  end

  assign init_load = !init_done_q && (init_cnt_q == INIT_W'(INIT_CYCLES));

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path.

  // Address and data are taken in either order; the response waits for both.
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
  assign wr_fire       = aw_got_q && w_got_q && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
      end
    end
  end

  // Write response; unmapped offsets answer with a decode error.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_q[7:0] <= WRPTR_OFS && awaddr_q[1:0] == 2'h0 &&
                       awaddr_q[7:0] != STATUS_OFS && awaddr_q[7:0] != ANGLE_OFS)
                      ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign turn_clear = wr_fire && awaddr_q[7:0] == CTRL_OFS && wstrb_q[0] &&
                      wdata_q[CTRL_TURN_CLR_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  // Shadow reload at the end of init overrides any earlier software write except one to the write pointer.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_en_q  <= 1'b0;
      err_sel_q <= 1'b0;
      mask_a_q <= 1'b0;
      mask_m_q <= 1'b0;
      period_q <= '0;
      wrptr_q  <= WRPTR_RESET;
    end else if (init_load) begin
      err_en_q  <= ee_pwm_error_output_enable;
      err_sel_q <= ee_pwm_error_signalling_select;
      mask_a_q <= ee_mask_analog;
      mask_m_q <= ee_mask_main;
      period_q <= ee_period;
    end else if (wr_fire) begin
      unique case (awaddr_q[7:0])
        CTRL_OFS: begin
          if (wstrb_q[0]) begin
            err_en_q  <= wdata_q[CTRL_ERR_EN_BIT];
            err_sel_q <= wdata_q[CTRL_ERR_SEL_BIT];
            mask_a_q <= wdata_q[CTRL_MASKA_BIT];
            mask_m_q <= wdata_q[CTRL_MASKM_BIT];
          end
        end
        PERIOD_OFS: begin
          if (wstrb_q[0]) period_q[7:0] <= wdata_q[7:0];
          if (wstrb_q[1]) period_q[15:8] <= wdata_q[15:8];
          if (wstrb_q[2]) period_q[19:16] <= wdata_q[19:16];
        end
        WRPTR_OFS: begin
          if (wstrb_q[0]) wrptr_q <= wdata_q[PTR_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path.

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr[7:0])
      CTRL_OFS: begin
        rd_val[CTRL_ERR_EN_BIT]  = err_en_q;
        rd_val[CTRL_ERR_SEL_BIT] = err_sel_q;
        rd_val[CTRL_MASKA_BIT] = mask_a_q;
        rd_val[CTRL_MASKM_BIT] = mask_m_q;
      end
      PERIOD_OFS: rd_val[PERIOD_W-1:0] = period_q;
      STATUS_OFS: begin
        rd_val[STAT_REPORT_LSB +: FAULT_N] = report_q;
        rd_val[STAT_ERR_BIT]  = err_rep;
        rd_val[STAT_HIZ_BIT]  = hiz_q;
        rd_val[STAT_INIT_BIT] = init_done_q;
      end
      ANGLE_OFS: rd_val[ANGLE_W-1:0] = angle_q;
      WRPTR_OFS: rd_val[PTR_W-1:0] = wrptr_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // One read at a time; data is registered on the same edge that takes the address.
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Angle sampling.

  // The angle is sampled on a fixed grid so the PWM never sees a half-updated value.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ang_cnt_q <= '0;
      angle_q   <= '0;
    end else if (ang_cnt_q == ANGC_W'(ANG_UPDATE_CLK - 1)) begin
      ang_cnt_q <= '0;
      angle_q   <= angle_in;
    end else begin
      ang_cnt_q <= ang_cnt_q + ANGC_W'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fault capture.

  // Permanent faults stick until reset; turn overflow until software clears it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      perm_q  <= '0;
      turns_q <= 1'b0;
    end else begin
      if (watchdog_fault) perm_q[F_WATCHDOG] <= 1'b1;
      if (eeprom_uncorrectable_fault) perm_q[F_EE_UNCORR] <= 1'b1;
      if (selftest_fault) perm_q[F_SELFTEST] <= 1'b1;
      // A new overflow in the clearing cycle wins over the clear.
      if (turn_count_overflow) turns_q <= 1'b1;
      else if (turn_clear) turns_q <= 1'b0;
    end
  end

  always_comb begin
    live               = '0;
    live[F_WATCHDOG]   = watchdog_fault || perm_q[F_WATCHDOG];
    live[F_EE_UNCORR]  = eeprom_uncorrectable_fault || perm_q[F_EE_UNCORR];
    live[F_SELFTEST]   = selftest_fault || perm_q[F_SELFTEST];
    live[F_PLL]        = pll_unlock_fault;
    live[F_ZERO_CROSS] = zero_cross_integrity_fault;
    live[F_MEAN]       = mean_filter_fault;
    live[F_SUPPLY]     = (analog_supply_undervoltage && !mask_a_q) ||
                         (main_supply_undervoltage && !mask_m_q);
    live[F_WEAK]       = weak_field_fault;
    live[F_EE_CORR]    = eeprom_corrected_fault;
    live[F_CLIP]       = clip_fault;
    live[F_STRONG]     = strong_field_fault;
    live[F_TEMP]       = temperature_window_fault;
    live[F_TURNS]      = turn_count_overflow || turns_q;
  end

  // Anything seen during a period is reported for the whole next period, then dropped
  // unless still live, so one-shot faults show exactly once.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seen_q   <= '0;
      report_q <= '0;
    end else if (period_end) begin
      report_q <= seen_q | live;
      seen_q   <= '0;
    end else begin
      seen_q <= seen_q | live;
    end
  end

  assign err_rep = err_en_q && (report_q != '0);

  // Priority encoder: the lowest index wins.
  always_comb begin
    code = 11'(DUTY_MIN);
    for (int i = FAULT_N - 1; i >= 0; i--) begin
      if (seen_q[i] || live[i]) code = 11'(CODE_FIRST + CODE_STEP * i);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // PWM generation.

  // Next period and high time, from the faults about to be reported, so none lags a period.
  always_comb begin
    next_period = {1'b0, period_q};
    if (err_en_q && err_sel_q && (seen_q | live) != '0) next_period = {period_q, 1'b0};
    if (err_en_q && (seen_q | live) != '0) begin
      next_high = (PERIOD_W+1)'((48'(next_period) * 48'(code)) / 48'(DUTY_DEN));
    end else begin
      next_high = (PERIOD_W+1)'((48'(next_period) * 48'(DUTY_MIN) +
                  (48'(next_period) * 48'(DUTY_SPAN) * 48'(angle_q)) /
                  48'(4095)) / 48'(DUTY_DEN));
    end
    // Keep at least one low and one high cycle so the pin never sits constant.
    if (next_high == '0) next_high = (PERIOD_W+1)'(1);
    if (next_high >= next_period) next_high = next_period - (PERIOD_W+1)'(1);
  end

  assign period_end = init_done_q && (cnt_q + (PERIOD_W+1)'(1) >= cur_period_q);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q        <= '0;
      cur_period_q <= '0;
      high_q       <= '0;
    end else if (period_end) begin
      cnt_q        <= '0;
      cur_period_q <= next_period;
      high_q       <= next_high;
    end else if (init_done_q) begin
      cnt_q <= cnt_q + (PERIOD_W+1)'(1);
    end
  end

  // Tristate is sticky until power cycle once a fault is shown with select clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hiz_q <= 1'b0;
    end else if (err_rep && !err_sel_q) begin
      hiz_q <= 1'b1;
    end
  end

  // Registered pin: high from period start until the high count expires.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwm_o  <= 1'b0;
      pwm_oe <= 1'b1;
    end else begin
      pwm_o  <= init_done_q && (period_end || cnt_q + (PERIOD_W+1)'(1) < high_q);
      pwm_oe <= !(hiz_q || (err_rep && !err_sel_q));
    end
  end
endmodule

// >>> testbench/angle_pwm_monitor.sv
// Port-level checker for the angle PWM encoder.
`timescale 1ns/1ps
module angle_pwm_monitor
  import angle_pwm_pkg::*;
(
  input wire logic                          clk,
  input wire logic                          rst_n,
  input wire logic                          s_axi_awvalid,
  input wire logic                          s_axi_awready,
  input wire logic                          s_axi_wvalid,
  input wire logic                          s_axi_wready,
  input wire logic [1:0]                    s_axi_bresp,
  input wire logic                          s_axi_bvalid,
  input wire logic                          s_axi_bready,
  input wire logic                          s_axi_arvalid,
  input wire logic                          s_axi_arready,
  input wire logic [31:0]                   s_axi_rdata,
  input wire logic [1:0]                    s_axi_rresp,
  input wire logic                          s_axi_rvalid,
  input wire logic                          s_axi_rready,
  input wire logic [angle_pwm_pkg::PERIOD_W-1:0] ee_period,
  input wire logic                          pwm_o,
  input wire logic                          pwm_oe
);
  logic [20:0] hi_q;
  logic [20:0] gap_q;
  logic        seen_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////////
  // Length of the current driven high run; a stuck-high pin would grow it past any period.
  always_ff @(posedge clk) begin
    if (!rst_n || !pwm_o || !pwm_oe) hi_q <= 21'h0;
    else hi_q <= hi_q + 21'h1;
  end
  // Cycles since the last rising edge; the first edge after reset only arms the count.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gap_q  <= 21'h0;
      seen_q <= 1'b0;
    end else if ($rose(pwm_o)) begin
      gap_q  <= 21'h1;
      seen_q <= 1'b1;
    end else gap_q <= gap_q + 21'h1;
  end
  //////////////////////////////////////////////////////////////////////////////
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("Write response dropped early.");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("Read data dropped early.");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("Write response missing.");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |-> ##[1:2] s_axi_rvalid) else $error("Read data missing.");
  a_busy_refused: assert property ((s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    and (s_axi_rvalid |-> !s_axi_arready)) else $error("Request taken while busy.");
  a_decerr_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_DECERR
    |-> s_axi_rdata == 32'h0) else $error("Error read returned data.");
  a_tristate_sticky: assert property (!pwm_oe |=> !pwm_oe)
    else $error("Tristate released without reset.");
  a_never_flat: assert property (hi_q < {ee_period, 1'b0})
    else $error("Output held high too long.");
  a_period_grid: assert property ($rose(pwm_o) && seen_q
    |-> gap_q == {1'b0, ee_period} || gap_q == {ee_period, 1'b0}) else $error("Period off grid.");
  a_reset_state: assert property (disable iff (1'b0) !rst_n
    |=> !s_axi_bvalid && !s_axi_rvalid && pwm_oe && !pwm_o) else $error("Bad reset outputs.");
endmodule
bind angle_pwm_error_encoder angle_pwm_monitor u_mon (.clk, .rst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .ee_period, .pwm_o, .pwm_oe);

// >>> testbench/pwm_capture_model.sv
// Host-side capture of the PWM pin: high time and period of each cycle.
`timescale 1ns/1ps
module pwm_capture_model (
  input  wire logic clk,
  input  wire logic pwm_o,
  input  wire logic pwm_oe,
  output int        hi,
  output int        per,
  output logic      stb
);
  int   hc;
  int   pc;
  logic pin;
  logic prev = 1'b0;
  // The host line has a pull-down, so a tristated pin reads low.
  assign pin = pwm_oe ? pwm_o : 1'b0;
  //////////////////////////////////////////////////////////////////////////////
  // A rising edge closes one period, as the host keys on rising edges only.
  always_ff @(posedge clk) begin
    prev <= pin;
    stb  <= 1'b0;
    if (pin && !prev) begin
      hi  <= hc;
      per <= pc;
      stb <= 1'b1;
      hc  <= 1;
      pc  <= 1;
    end else begin
      pc <= pc + 1;
      hc <= hc + (pin ? 1 : 0);
    end
  end
endmodule

// >>> testbench/tb_angle_pwm_error_encoder.sv
// Self-checking bench for the angle PWM encoder with fault codes.
`timescale 1ns/1ps
module tb_angle_pwm_error_encoder;
  import angle_pwm_pkg::*;
  localparam int P = 160;
  logic        clk = 1'b0;
  logic        rst_n, awv, wv, arv, en, sel, mka, mkm, uvm, awr, wr, bv, arr, rv, stb, oe, po;
  logic [1:0]  br, rr, r;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd, d;
  logic [11:0] ang;
  logic [12:0] f;
  logic [19:0] per_in = 20'h000A0;
  int          hi, per, n_errors, checks_done, a;
  angle_pwm_error_encoder #(.INIT_CYCLES(20)) dut (
    .clk, .rst_n, .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(1'b1), .angle_in(ang),
    .ee_pwm_error_output_enable(en), .ee_pwm_error_signalling_select(sel),
    .ee_mask_analog(mka), .ee_mask_main(mkm), .ee_period(per_in),
    .watchdog_fault(f[0]), .eeprom_uncorrectable_fault(f[1]), .selftest_fault(f[2]),
    .pll_unlock_fault(f[3]), .zero_cross_integrity_fault(f[4]), .mean_filter_fault(f[5]),
    .analog_supply_undervoltage(f[6]), .main_supply_undervoltage(uvm),
    .weak_field_fault(f[7]), .eeprom_corrected_fault(f[8]), .clip_fault(f[9]),
    .strong_field_fault(f[10]), .temperature_window_fault(f[11]),
    .turn_count_overflow(f[12]), .pwm_o(po), .pwm_oe(oe));
  pwm_capture_model host (.clk, .pwm_o(po), .pwm_oe(oe), .hi, .per, .stb);
  //////////////////////////////////////////////////////////////////////////////
  // Free-running 200 MHz clock.
  initial forever #2.5 clk = ~clk;
  // Mismatch reporting and the single place where the run ends.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic final_report();
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Reference duty in clock cycles: angle mapped onto 5..95 percent, faults on a fixed ladder.
  function automatic int ang_hi(int v);
    int h;
    h = (P * 80 + (P * 1440 * v) / 4095) / 1600;
    return h < 1 ? 1 : (h > P - 1 ? P - 1 : h);
  endfunction
  function automatic int flt_hi(int i);
    return (2 * P * (80 + 90 * i)) / 1600;
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // Bus master: address and data offered together, each released when taken.
  task automatic axw(input logic [7:0] ad, input logic [31:0] dd, output logic [1:0] rs);
    awa <= ad;
    wd  <= dd;
    awv <= 1'b1;
    wv  <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    rs = br;
  endtask
  task automatic axr(input logic [7:0] ad, output logic [31:0] dd, output logic [1:0] rs);
    ara <= ad;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    dd = rd;
    rs = rr;
  endtask
  // Early periods after a change are skipped, since faults surface one period late.
  task automatic meas(input int n, input int eh, input int ep);
    repeat (n) @(posedge stb);
    @(posedge clk);
    chk("pwm_high", eh, hi);
    chk("pwm_period", ep, per);
  endtask
  task automatic reboot();
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (30) @(posedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {awv, wv, arv, uvm, f, awa, ara, wd, ang} <= '0;
    {en, sel, mka, mkm} <= 4'hE;
    a = $urandom(52397);
    reboot();
    axr(CTRL_OFS, d, r);
    chk("ctrl_load", 32'h0000000B, d);
    axr(8'h14, d, r);
    chk("unmapped_resp", RESP_DECERR, r);
    chk("unmapped_data", 32'h0, d);
    axw(STATUS_OFS, 32'hFFFFFFFF, r);
    chk("ro_resp", RESP_DECERR, r);
    f[6] <= 1'b1;
    meas(4, ang_hi(0), P);
    uvm <= 1'b1;
    meas(4, flt_hi(6), 2 * P);
    {f[6], uvm, mka} <= 3'h0;
    // Both ends of the angle range, then random angles.
    for (int k = 0; k < 6; k++) begin
      a = (k == 0) ? 0 : (k == 1) ? 4095 : $urandom_range(4095);
      ang <= a[11:0];
      meas(4, ang_hi(a), P);
    end
    // Every fault alone, each after a fresh power-up so permanent ones start clean.
    for (int i = 0; i < 13; i++) begin
      axw(WRPTR_OFS, $urandom, r);
      reboot();
      axr(WRPTR_OFS, d, r);
      chk("wrptr_reset", 32'h0, d);
      if (i == 5 || i == 8) begin
        @(posedge stb);
        f[i] <= 1'b1;
        @(posedge clk);
        f[i] <= 1'b0;
        meas(2, flt_hi(i), 2 * P);
        meas(1, ang_hi(a), P);
      end else begin
        f[i] <= 1'b1;
        meas(4, flt_hi(i), 2 * P);
        f[i] <= 1'b0;
        meas(4, (i < 3 || i == 12) ? flt_hi(i) : ang_hi(a),
             (i < 3 || i == 12) ? 2 * P : P);
        if (i == 12) begin
          axw(CTRL_OFS, 32'h7, r);
          meas(4, ang_hi(a), P);
        end
      end
    end
    f[3] <= 1'b1;
    f[4 + $urandom_range(8)] <= 1'b1;
    meas(4, flt_hi(3), 2 * P);
    f <= '0;
    axw(CTRL_OFS, 32'h2, r);
    f[9] <= 1'b1;
    meas(4, ang_hi(a), P);
    axw(CTRL_OFS, 32'h1, r);
    repeat (4 * P) @(posedge clk);
    chk("pin_enable", 1'b0, oe);
    f[9] <= 1'b0;
    repeat (4 * P) @(posedge clk);
    chk("pin_enable", 1'b0, oe);
    reboot();
    chk("pin_enable", 1'b1, oe);
    final_report();
  end
  // Watchdog sized well beyond the expected run length.
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    final_report();
  end
endmodule
